// file: sim/gate_driver_model.sv
// Purpose: stand-in for the switch gate drivers
// Assumes: each driver follows its command one to one
// Notes: counts turn-on edges only
`timescale 1ns/1ns
`default_nettype none
module gate_driver_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // gate commands
    input wire logic out_a,
    input wire logic out_b,
    // turn-on counts
    output var int a_rises,
    output var int b_rises
);
    logic a_q;
    logic b_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            a_rises <= 0;
            b_rises <= 0;
        end else begin
            a_q <= out_a;
            b_q <= out_b;
            a_rises <= a_rises + int'(out_a && !a_q);
            b_rises <= b_rises + int'(out_b && !b_q);
        end
    end
endmodule : gate_driver_model
`default_nettype wire

// file: sim/pulse_width_channel_tb_top.sv
// Purpose: self-checking bench of the pulse-width channel
// Assumes: zero-wait apb, 125 MHz pclk
// Notes: sync pulsed once; compensator period driven in the resonant check
`include "pwm_event_map.svh"
`timescale 1ns/1ns
`default_nettype none
module pulse_width_channel_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [15:0] duty = 16'h0;
    logic [13:0] cper = 14'h0000;
    logic sync = 1'b0;
    logic duty_vld = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, phase_trig, ec_start, out_a, out_b, period_irq;
    logic [3:0] a_phase, b_phase, ap, bp;
    int a_rises, b_rises, a0, b0, p, e1, e2, e3, e4, hi, per, n, ec, ph, irq;
    int mismatches = 0;
    int samples_checked = 0;
    int regs[7];
    int dv[2] = '{1, 5};
    always #4 pclk = ~pclk;
    pulse_width_channel DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .compensator_output(duty), .compensator_period(cper),
        .compensator_valid(duty_vld), .sync_in(sync), .phase_trig(phase_trig),
        .error_converter_start(ec_start), .out_a(out_a), .out_b(out_b), .a_phase(a_phase),
        .b_phase(b_phase), .period_irq(period_irq));
    gate_driver_model u_drv (.pclk(pclk), .presetn(presetn), .out_a(out_a), .out_b(out_b),
        .a_rises(a_rises), .b_rises(b_rises));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic close_out;
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic tick(inout int c);
        @(posedge pclk);
        c++;
        if (c > 20000) begin
            mismatches++;
            close_out();
        end
    endtask : tick
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do tick(k); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] x, input logic ex);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(what, r, x);
        check("slave error", {31'h0, e}, {31'h0, ex});
    endtask : rd
    task automatic lvl(input bit s, input logic v, inout int c);
        while ((s ? out_b : out_a) !== v) tick(c);
    endtask : lvl
    task automatic meas(input bit s);
        n = 0;
        lvl(s, 1'b0, n);
        lvl(s, 1'b1, n);
        hi = 0;
        lvl(s, 1'b0, hi);
        per = hi;
        lvl(s, 1'b1, per);
    endtask : meas
    task automatic gap;
        lvl(0, 1'b1, n);
        lvl(0, 1'b0, n);
        n = 0;
        lvl(1, 1'b1, n);
    endtask : gap
    // settles two periods, then counts events over k cycles
    task automatic count(input int k);
        repeat (2 * (p + 1)) @(posedge pclk);
        ec = 0;
        ph = 0;
        irq = 0;
        ap = 4'h0;
        bp = 4'h0;
        a0 = a_rises;
        b0 = b_rises;
        repeat (k) begin
            @(posedge pclk);
            ec += int'(ec_start === 1'b1);
            ph += int'(phase_trig === 1'b1);
            irq += int'(period_irq === 1'b1);
            ap |= a_phase;
            bp |= b_phase;
        end
    endtask : count
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hE6B9));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd("ctrl", `OFS_CTRL, {21'h0, `RST_CTRL}, 1'b0);
        rd("period", `OFS_PERIOD, {18'h0, `RST_PERIOD}, 1'b0);
        rd("hole", 12'h030, 32'h0, 1'b1);
        p = 32'h7F + 32 * ($urandom % 4);
        e1 = 1 + $urandom % 4;
        e2 = 20 + $urandom % 16;
        e3 = e2 + 5;
        e4 = e3 + 20;
        regs = '{32'hFFFF_C000 | p, e1, e2 << 4, e3 << 4, e4 << 4, 8, 10};
        foreach (regs[i]) wr(12'h004 + 12'(4 * i), regs[i]);
        rd("period", `OFS_PERIOD, p, 1'b0);
        wr(`OFS_CTRL, 1);
        count(p);
        meas(0);
        check("a width", hi, e2 - e1);
        check("a period", per, p + 1);
        meas(1);
        check("b width", hi, e4 - e3);
        check("b period", per, p + 1);
        gap();
        check("a to b", n, e3 - e2);
        n = 0;
        while (phase_trig !== 1'b1) tick(n);
        n = 0;
        while (ec_start !== 1'b1) tick(n);
        check("trigger spacing", n, 4 * 8 - 10);
        n = 0;
        while (phase_trig !== 1'b1) tick(n);
        sync <= 1'b1;
        tick(n);
        sync <= 1'b0;
        n = 0;
        while (phase_trig !== 1'b1) tick(n);
        check("sync to trigger", n, 10 + 2);
        wr(`OFS_ADJA, 32'h30);
        count(p);
        meas(0);
        check("a trimmed", hi, e2 - e1 + 3);
        wr(`OFS_ADJA, 32'h0);
        wr(`OFS_EV2, (e2 << 4) | 15);
        wr(`OFS_EV3, (e3 << 4) | 15);
        for (int r = 0; r < 5; r++) begin
            wr(`OFS_CTRL, r < 4 ? 1 | (r << 5) : 17);
            count(p + 1);
            check("a phase", {28'h0, ap}, r < 4 ? 15 & ~((1 << r) - 1) : 0);
            check("b phase", {28'h0, bp}, r < 4 ? 15 & ~((1 << r) - 1) : 0);
        end
        wr(`OFS_EV2, e2 << 4);
        wr(`OFS_EV3, e3 << 4);
        wr(`OFS_STRIG, 0);
        for (int o = 0; o < 4; o++) begin
            wr(`OFS_CTRL, 1 | (o << 7));
            count(8 * (p + 1));
            check("samples", ec, 8 << o);
            check("phase trigs", ph, 8);
            check("irqs", irq, 8);
        end
        foreach (dv[i]) begin
            wr(`OFS_IDIV, dv[i]);
            count(4 * (dv[i] + 1) * (p + 1));
            check("irqs divided", irq, 4);
        end
        duty <= 16'h4000;
        duty_vld <= 1'b1;
        wr(`OFS_ADJB, 32'h10);
        for (int m = 0; m < 4; m++) begin
            wr(`OFS_CTRL, 1 | (m << 1));
            count(8 * (p + 1));
            check("a pulses", a_rises - a0, 8);
            check("b pulses", b_rises - b0, 8);
        end
        wr(`OFS_EV1, 0);
        wr(`OFS_EV4, (p - 2) << 4);
        duty <= 16'h1000 + 16'($urandom % 32'h5000);
        wr(`OFS_CTRL, 9);
        count(p);
        meas(0);
        check("loop width", hi, (((duty * p * 16) >> 15) + 15) >> 4);
        gap();
        check("loop dead time", n, e3 - e2);
        cper <= 14'(p - 32);
        wr(`OFS_CTRL, 13);
        count(p);
        meas(0);
        check("resonant period", per, p - 31);
        close_out();
    end
endmodule : pulse_width_channel_tb_top
`default_nettype wire

// file: sim/pwc_asserts.sv
// Purpose: port-level checks of the pulse-width channel
// Assumes: period kept at 007F or above
// Notes: bound to the design at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module pwc_asserts #(
    parameter int CW = 14,
    parameter int FW = 18
) (
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // compensator and sync
    input wire logic [15:0] compensator_output,
    input wire logic [CW-1:0] compensator_period,
    input wire logic compensator_valid,
    input wire logic sync_in,
    // channel outputs
    input wire logic phase_trig,
    input wire logic error_converter_start,
    input wire logic out_a,
    input wire logic out_b,
    input wire logic [3:0] a_phase,
    input wire logic [3:0] b_phase,
    input wire logic period_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    a_zero_wait: assert property (s_setup ##1 s_access |-> pready)
        else $error("pready low in access phase");
    a_read_hold: assert property (s_access |=> $stable(prdata))
        else $error("read data moved after access");
    a_err_access: assert property (pslverr |-> s_access)
        else $error("error flag outside access");
    a_map_decode: assert property (s_access |-> pslverr == (paddr > 12'h02C || paddr[1:0] != 2'h0))
        else $error("error flag disagrees with map");
    a_sample_gap: assert property (error_converter_start |=> !error_converter_start [*3])
        else $error("sample start off control clock grid");
    a_trig_single: assert property (phase_trig |=> !phase_trig [*8])
        else $error("phase trigger repeated");
    a_irq_gap: assert property (period_irq |=> !period_irq [*8])
        else $error("interrupt repeated within a period");
    a_quiet_start: assert property ($rose(presetn) |-> !out_a && !out_b && !period_irq)
        else $error("outputs active straight after reset");
endmodule : pwc_asserts
bind pulse_width_channel pwc_asserts #(.CW(CW), .FW(FW)) u_pwc_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compensator_output(compensator_output), .compensator_period(compensator_period),
    .compensator_valid(compensator_valid), .sync_in(sync_in), .phase_trig(phase_trig),
    .error_converter_start(error_converter_start), .out_a(out_a), .out_b(out_b),
    .a_phase(a_phase), .b_phase(b_phase), .period_irq(period_irq)
);
`default_nettype wire

// file: src/pulse_width_channel.sv
// Purpose: one pulse-width channel, outputs A and B, with APB registers
// Assumes: pclk is the pulse clock; compensator values arrive synchronously
// Notes: sub-clock edge phase is handed out on a_phase/b_phase for a delay line
//
// Contract
// - sample trigger match starts error converter
// - sample compare in quarter-rate control clock units
// - oversampling 1, 2, 4, 8 per period
// - phase trigger count issues phase trigger
// - period is 14-bit coarse count
// - frequency is pulse clock over period+1
// - event 1 raises A, coarse
// - events 2,3,4: 14 coarse plus 4 phase
// - cycle adjust offsets events 2 and 4; resonant mode never offsets event 2, and offsets event 4 only in open loop
// - edges from event versus counter compares
// - normal, phase, resonant, multi modes
// - normal closed loop: compensator sets event 2
// - normal: event 3 keeps event 3-2 delta
// - normal: event 4 to 1 dead time
// - phase mode: compensator sets phase offset
// - resonant: compensator sets event 2, period
// - resonant: keep 2-3 and period-4 deltas
// - multi: equal widths from event 1, 3
// - multi: B may wrap; adjust A, B
// - fine disable bit, 2-bit resolution
// - period interrupt divided up to 255
// - Q15 duty times period gives on time
// - sync in resets counter, out at threshold
//
// The address map and the APB interface to the registers were left to the implementer.
`include "pwm_event_map.svh"
`timescale 1ns/1ns
`default_nettype none

module pulse_width_channel #(
    parameter int CW = 14,
    parameter int FW = 18
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // compensator side
    input wire logic [15:0] compensator_output,
    input wire logic [CW-1:0] compensator_period,
    input wire logic compensator_valid,
    // synchronisation
    input wire logic sync_in,
    output logic phase_trig,
    // error converter
    output logic error_converter_start,
    // switch drivers
    output logic out_a,
    output logic out_b,
    output logic [3:0] a_phase,
    output logic [3:0] b_phase,
    // cpu event
    output logic period_irq
);

    typedef struct packed {
        logic [`CTRL_W-1:0] ctrl;
        logic [CW-1:0] period;
        logic [CW-1:0] ev1;
        logic [FW-1:0] ev2;
        logic [FW-1:0] ev3;
        logic [FW-1:0] ev4;
        logic [CW-3:0] strig;
        logic [CW-1:0] ptrig;
        logic [15:0] adja;
        logic [15:0] adjb;
        logic [7:0] idiv;
        logic [15:0] duty;
        logic [CW-1:0] cper;
        logic [CW-1:0] cnt;
        logic [CW-1:0] per_act;
        logic [CW-1:0] e1;
        logic [FW-1:0] e2;
        logic [FW-1:0] e3;
        logic [FW-1:0] e4;
        logic [CW-1:0] phase_off;
        logic [CW-3:0] os_next;
        logic [2:0] os_left;
        logic [7:0] icnt;
        logic a;
        logic b;
        logic [3:0] ap;
        logic [3:0] bp;
        logic smp;
        logic pt;
        logic irq;
        logic [31:0] rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    pwm_event_pkg::mode_t mode;
    pwm_event_pkg::res_t res;
    logic closed;
    logic wrap;
    logic [FW-1:0] per_f;
    logic [FW-1:0] t_now;
    logic [FW-1:0] on_time;
    logic [33:0] prod;
    logic [FW-1:0] n2;
    logic [FW-1:0] n3;
    logic [FW-1:0] n4;
    logic [CW-1:0] nper;
    logic [FW-1:0] wrap_len;
    logic [FW-1:0] adja_x;
    logic [FW-1:0] adjb_x;
    logic [CW-1:0] adja_coarse;
    logic [3:0] fmask;
    logic [3:0] bmask;
    logic a_on;
    logic b_on;
    logic mapped;
    logic [CW-3:0] spacing;
    logic [CW-3:0] ctl_cnt;
    logic ctl_tick;

    assign mode = pwm_event_pkg::mode_t'(s_q.ctrl[`CTRL_MODE_LO +: 2]);
    assign res = pwm_event_pkg::res_t'(s_q.ctrl[`CTRL_RES_LO +: 2]);
    assign closed = s_q.ctrl[`CTRL_CLOSED];

    // --------------------------------------------------------------
    // apb handshake
    // --------------------------------------------------------------
    always_comb begin
        case (paddr)
            `OFS_CTRL, `OFS_PERIOD, `OFS_EV1, `OFS_EV2, `OFS_EV3, `OFS_EV4,
            `OFS_STRIG, `OFS_PTRIG, `OFS_ADJA, `OFS_ADJB, `OFS_IDIV, `OFS_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // zero wait states: every transfer answers in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = s_q.rdata;

    // --------------------------------------------------------------
    // combinational event math
    // --------------------------------------------------------------
    always_comb begin
        wrap = (s_q.cnt >= s_q.per_act);
        per_f = {s_q.per_act, 4'h0};
        t_now = {s_q.cnt, 4'h0};
        // full-scale duty times longest period needs 34 bits
        prod = 34'(s_q.duty) * 34'(per_f);
        on_time = prod[`Q15_SHIFT +: FW];
        // adjust values are signed sixteenths of a clock
        adja_x = FW'({{2{s_q.adja[15]}}, s_q.adja});
        adjb_x = FW'({{2{s_q.adjb[15]}}, s_q.adjb});
        adja_coarse = {{(CW-12){s_q.adja[15]}}, s_q.adja[15:4]};
        nper = s_q.period;
        n2 = s_q.ev2 + adja_x;
        n3 = s_q.ev3;
        n4 = s_q.ev4 + adjb_x;
        // closed loop recomputes events each cycle; shadows load at wrap
        case (mode)
            pwm_event_pkg::MODE_NORMAL: begin
                if (closed) begin
                    n2 = {s_q.ev1, 4'h0} + on_time + adja_x;
                    n3 = n2 + (s_q.ev3 - s_q.ev2);
                end
            end
            pwm_event_pkg::MODE_PHASE: begin
                n2 = s_q.ev2 + adja_x;
            end
            pwm_event_pkg::MODE_RESONANT: begin
                if (closed) begin
                    nper = s_q.cper + adja_coarse;
                    n2 = {s_q.ev1, 4'h0} + on_time;
                    n3 = n2 + (s_q.ev3 - s_q.ev2);
                    n4 = {nper, 4'h0} - ({s_q.period, 4'h0} - s_q.ev4);
                end else begin
                    n2 = s_q.ev2;
                end
            end
            pwm_event_pkg::MODE_MULTI: begin
                // event 3 is coarse only in multi mode
                n3 = {s_q.ev3[FW-1:4], 4'h0};
                if (closed) begin
                    n2 = {s_q.ev1, 4'h0} + on_time + adja_x;
                    n4 = n3 + on_time + adjb_x;
                end else begin
                    n4 = n3 + (s_q.ev4 - s_q.ev3) + adjb_x;
                end
            end
            default: begin
                n2 = s_q.ev2;
            end
        endcase
        // phase quantisation
        case (res)
            pwm_event_pkg::RES_16: fmask = 4'hF;
            pwm_event_pkg::RES_8: fmask = 4'hE;
            pwm_event_pkg::RES_4: fmask = 4'hC;
            pwm_event_pkg::RES_2: fmask = 4'h8;
            default: fmask = 4'hF;
        endcase
        if (s_q.ctrl[`CTRL_FINE_OFF]) begin
            fmask = 4'h0;
        end
        bmask = (mode == pwm_event_pkg::MODE_MULTI) ? 4'h0 : fmask;
        // B may run past the period end in multi mode
        wrap_len = per_f + FW'(16);
        a_on = (t_now >= {s_q.e1, 4'h0}) && (t_now < s_q.e2);
        if (s_q.e4 >= wrap_len) begin
            b_on = (t_now >= s_q.e3) || (t_now < (s_q.e4 - wrap_len));
        end else begin
            b_on = (t_now >= s_q.e3) && (t_now < s_q.e4);
        end
        // control clock ticks on every fourth pulse clock
        ctl_cnt = s_q.cnt[CW-1:`CTRL_DIV];
        ctl_tick = (s_q.cnt[`CTRL_DIV-1:0] == 2'h0);
        // oversample spacing in control ticks: one period split 1, 2, 4 or 8 ways
        spacing = (CW-2)'(({2'h0, s_q.per_act[CW-1:`CTRL_DIV]} + (CW)'(1)) >> s_q.ctrl[`CTRL_OS_LO +: 2]);
    end

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.smp = 1'b0;
        s_d.pt = 1'b0;
        s_d.irq = 1'b0;

        // register writes, taken at the access edge
        if (psel && penable && pwrite) begin
            case (paddr)
                `OFS_CTRL: s_d.ctrl = pwdata[`CTRL_W-1:0];
                `OFS_PERIOD: s_d.period = pwdata[CW-1:0];
                `OFS_EV1: s_d.ev1 = pwdata[CW-1:0];
                `OFS_EV2: s_d.ev2 = pwdata[FW-1:0];
                `OFS_EV3: s_d.ev3 = pwdata[FW-1:0];
                `OFS_EV4: s_d.ev4 = pwdata[FW-1:0];
                `OFS_STRIG: s_d.strig = pwdata[CW-3:0];
                `OFS_PTRIG: s_d.ptrig = pwdata[CW-1:0];
                `OFS_ADJA: s_d.adja = pwdata[15:0];
                `OFS_ADJB: s_d.adjb = pwdata[15:0];
                `OFS_IDIV: s_d.idiv = pwdata[7:0];
                default: ;
            endcase
        end

        // read data captured in the setup phase
        if (psel && !penable) begin
            case (paddr)
                `OFS_CTRL: s_d.rdata = 32'(s_q.ctrl);
                `OFS_PERIOD: s_d.rdata = 32'(s_q.period);
                `OFS_EV1: s_d.rdata = 32'(s_q.ev1);
                `OFS_EV2: s_d.rdata = 32'(s_q.ev2);
                `OFS_EV3: s_d.rdata = 32'(s_q.ev3);
                `OFS_EV4: s_d.rdata = 32'(s_q.ev4);
                `OFS_STRIG: s_d.rdata = 32'(s_q.strig);
                `OFS_PTRIG: s_d.rdata = 32'(s_q.ptrig);
                `OFS_ADJA: s_d.rdata = 32'(s_q.adja);
                `OFS_ADJB: s_d.rdata = 32'(s_q.adjb);
                `OFS_IDIV: s_d.rdata = 32'(s_q.idiv);
                `OFS_STATUS: s_d.rdata = {s_q.duty, 2'h0, s_q.cnt};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // compensator result
        if (compensator_valid) begin
            s_d.duty = compensator_output;
            s_d.cper = compensator_period;
            s_d.phase_off = on_time[FW-1:4];
        end

        // disabled channel holds A and B inactive (low unless the polarity bit inverts them) and tracks the period register
        if (!s_q.ctrl[`CTRL_EN]) begin
            s_d.cnt = '0;
            s_d.per_act = s_q.period;
            s_d.a = 1'b0;
            s_d.b = 1'b0;
            s_d.os_left = 3'h0;
        end else begin
            // period counter
            if (sync_in) begin
                if (mode == pwm_event_pkg::MODE_PHASE && closed && s_q.phase_off != '0) begin
                    s_d.cnt = s_q.per_act + CW'(1) - s_q.phase_off;
                end else begin
                    s_d.cnt = '0;
                end
            end else if (wrap) begin
                s_d.cnt = '0;
            end else begin
                s_d.cnt = s_q.cnt + CW'(1);
            end
            // shadow load at end of period
            if (wrap) begin
                s_d.per_act = nper;
                s_d.e1 = s_q.ev1;
                s_d.e2 = {n2[FW-1:4], n2[3:0] & fmask};
                s_d.e3 = {n3[FW-1:4], n3[3:0] & bmask};
                s_d.e4 = {n4[FW-1:4], n4[3:0] & fmask};
                // one interrupt every idiv+1 periods
                if (s_q.icnt >= s_q.idiv) begin
                    s_d.icnt = 8'h00;
                    s_d.irq = 1'b1;
                end else begin
                    s_d.icnt = s_q.icnt + 8'h01;
                end
            end
            // phase trigger for slaved channels
            if (s_q.cnt == s_q.ptrig) begin
                s_d.pt = 1'b1;
            end
            // error converter sampling
            if (ctl_tick) begin
                if (ctl_cnt == s_q.strig) begin
                    s_d.smp = 1'b1;
                    s_d.os_next = s_q.strig + spacing;
                    s_d.os_left = 3'((4'h1 << s_q.ctrl[`CTRL_OS_LO +: 2]) - 4'h1);
                end else if (s_q.os_left != 3'h0 && ctl_cnt == s_q.os_next) begin
                    s_d.smp = 1'b1;
                    s_d.os_next = s_q.os_next + spacing;
                    s_d.os_left = s_q.os_left - 3'h1;
                end
            end
            // outputs and edge phases
            s_d.a = a_on;
            s_d.b = b_on;
            s_d.ap = (s_q.cnt == s_q.e2[FW-1:4]) ? s_q.e2[3:0] : 4'h0;
            s_d.bp = (s_q.cnt == s_q.e3[FW-1:4]) ? s_q.e3[3:0] :
                     (s_q.cnt == s_q.e4[FW-1:4]) ? s_q.e4[3:0] : 4'h0;
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.ctrl <= `RST_CTRL;
            s_q.period <= `RST_PERIOD;
            s_q.per_act <= `RST_PERIOD;
        end else begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign out_a = s_q.a ^ s_q.ctrl[`CTRL_POL_A];
    assign out_b = s_q.b ^ s_q.ctrl[`CTRL_POL_B];
    assign a_phase = s_q.ap;
    assign b_phase = s_q.bp;
    assign error_converter_start = s_q.smp;
    assign phase_trig = s_q.pt;
    assign period_irq = s_q.irq;

endmodule : pulse_width_channel

`default_nettype wire

// file: src/pwm_event_map.svh
// Purpose: register offsets, field positions, reset values of the pulse-width channel
// Assumes: APB, 32-bit words, byte addresses
// Notes: definitions only
`ifndef PWM_EVENT_MAP_SVH
`define PWM_EVENT_MAP_SVH

`define OFS_CTRL 12'h000
`define OFS_PERIOD 12'h004
`define OFS_EV1 12'h008
`define OFS_EV2 12'h00C
`define OFS_EV3 12'h010
`define OFS_EV4 12'h014
`define OFS_STRIG 12'h018
`define OFS_PTRIG 12'h01C
`define OFS_ADJA 12'h020
`define OFS_ADJB 12'h024
`define OFS_IDIV 12'h028
`define OFS_STATUS 12'h02C

`define CTRL_EN 0
`define CTRL_MODE_LO 1
`define CTRL_CLOSED 3
`define CTRL_FINE_OFF 4
`define CTRL_RES_LO 5
`define CTRL_OS_LO 7
`define CTRL_POL_A 9
`define CTRL_POL_B 10
`define CTRL_W 11

`define RST_CTRL 11'h000
`define RST_PERIOD 14'h007F
`define CTRL_DIV 2
`define Q15_SHIFT 15

`endif

// file: src/pwm_event_pkg.sv
// Purpose: types of the pulse-width channel
// Assumes: nothing
// Notes: constants live in pwm_event_map.svh
package pwm_event_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PHASE = 2'b01,
        MODE_RESONANT = 2'b10,
        MODE_MULTI = 2'b11
    } mode_t;

    typedef enum logic [1:0] {
        RES_16 = 2'b00,
        RES_8 = 2'b01,
        RES_4 = 2'b10,
        RES_2 = 2'b11
    } res_t;

endpackage : pwm_event_pkg
